// ==== tbp_defs.svh ====
// Register offsets, field positions and reset values of the timer-based PWM generator
`ifndef TBP_DEFS_SVH
`define TBP_DEFS_SVH

// ==========================================================
// Sizes
`define TBP_NUM_MATCH 7
`define TBP_NUM_OUT 6
`define TBP_ADR_W 8

// ==========================================================
// Register byte offsets
`define TBP_OFF_CTRL 8'h00
`define TBP_OFF_COUNT 8'h04
`define TBP_OFF_PRESCALE 8'h08
`define TBP_OFF_PRE_COUNT 8'h0c
`define TBP_OFF_MATCH_CTRL 8'h10
`define TBP_OFF_RELEASE 8'h14
`define TBP_OFF_PWM_CTRL 8'h18
`define TBP_OFF_INT_STATUS 8'h1c
`define TBP_OFF_INT_MASK 8'h20
`define TBP_OFF_MATCH_BASE 8'h40

// ==========================================================
// Control register fields
`define TBP_CTRL_EN 0
`define TBP_CTRL_RST 1
`define TBP_CTRL_PWM 3
`define TBP_CTRL_MODE_LO 4
`define TBP_CTRL_MODE_HI 5
`define TBP_CTRL_CAPSEL 6

// Match control: three bits per match register
`define TBP_MC_INT 0
`define TBP_MC_RESET 1
`define TBP_MC_STOP 2
`define TBP_MC_STRIDE 3

// PWM control: double-edge select at bit n (outputs 2..6), enable at bit 8+n
`define TBP_PC_ENA_BASE 8

// ==========================================================
// Reset values
`define TBP_RST_WORD 32'h0000_0000
`define TBP_RST_REL 7'h00
`define TBP_RST_PTR 2'h0

`endif

// ==== tbp_pkg.sv ====
// Types shared by the timer-based PWM generator
`default_nettype none
package tbp_pkg;
  typedef logic [31:0] tbp_word_t;
  typedef enum logic [1:0] {TBP_TIMER, TBP_CAP_RISE, TBP_CAP_FALL, TBP_CAP_BOTH} tbp_cnt_mode_t;
endpackage
`default_nettype wire

// ==== tbp_pwm_ch.sv ====
// One PWM output stage: set and clear flip-flop driven by match events
`default_nettype none
module tbp_pwm_ch
  import tbp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic run,
  input wire logic set_ev,
  input wire logic clr_ev,
  input wire logic hold_low,
  output logic pwm_o
);

  // ==========================================================
  // Output flop
  // Clear wins over set so an edge match equal to the period match gives a low output
  always_ff @(posedge clk_sys)
  begin
    if (rst || !run)
    begin
      pwm_o <= 1'b0;
    end
    else if (clr_ev)
    begin
      pwm_o <= 1'b0;
    end
    else if (set_ev && !hold_low)
    begin
      pwm_o <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ==== tbp_top.sv ====
// Timer-based PWM generator with Wishbone register slave
//
// Our own choices: the Wishbone slave port and the placing of the registers.
`default_nettype none
`include "tbp_defs.svh"

module tbp_top
  import tbp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`TBP_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] cap_in,
  output logic [6:1] pwm_out,
  output logic irq
);

  // ==========================================================
  // Storage
  tbp_word_t ctrl;
  tbp_word_t count;
  tbp_word_t prescale;
  tbp_word_t pre_count;
  tbp_word_t match_ctrl;
  tbp_word_t pwm_ctrl;
  tbp_word_t int_status;
  tbp_word_t int_mask;
  logic [`TBP_NUM_MATCH-1:0] release_bits;
  tbp_word_t shadow [0:`TBP_NUM_MATCH-1];
  tbp_word_t active [0:`TBP_NUM_MATCH-1];

  logic [1:0] cap_s1;
  logic [1:0] cap_s2;
  logic [1:0] cap_s3;

  logic [`TBP_NUM_MATCH-1:0] match_ev;
  logic [`TBP_NUM_MATCH-1:0] int_en;
  logic [`TBP_NUM_MATCH-1:0] reset_en;
  logic [`TBP_NUM_MATCH-1:0] stop_en;
  logic [`TBP_NUM_MATCH-1:0] applied;
  logic [`TBP_NUM_MATCH-1:0] rel_wr;
  logic [`TBP_NUM_MATCH-1:0] w1c;

  tbp_cnt_mode_t mode;
  logic pwm_mode;
  logic count_en;
  logic cnt_edge;
  logic advance;
  logic tick;
  logic reset_hit;
  logic stop_hit;
  logic period_ev;
  logic access;
  logic wr_req;
  logic [5:0] word_sel;
  logic [5:0] match_word;
  logic match_hit;
  logic [2:0] match_idx;
  tbp_word_t next_rd;
  tbp_word_t wr_data;

  // ==========================================================
  // Byte-lane merge for writes
  function automatic tbp_word_t tbp_merge(input tbp_word_t old_v, input tbp_word_t new_v,
                                           input logic [3:0] sel);
    tbp_word_t r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Bus decode
  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_req = access && wb_we_i;
  assign word_sel = wb_adr_i[`TBP_ADR_W-1:2];
  assign match_word = word_sel - 6'(`TBP_OFF_MATCH_BASE >> 2);
  assign match_hit = (word_sel >= 6'(`TBP_OFF_MATCH_BASE >> 2)) &&
                     (match_word < 6'(`TBP_NUM_MATCH));
  assign match_idx = match_word[2:0];

  function automatic logic tbp_is(input logic [5:0] w, input logic [7:0] off);
    return w == off[7:2];
  endfunction

  assign wr_data = wb_dat_i;
  assign rel_wr = (wr_req && tbp_is(word_sel, `TBP_OFF_RELEASE)) ?
                  (wr_data[`TBP_NUM_MATCH-1:0] & {7{wb_sel_i[0]}}) : `TBP_RST_REL;
  assign w1c = (wr_req && tbp_is(word_sel, `TBP_OFF_INT_STATUS)) ?
               (wr_data[`TBP_NUM_MATCH-1:0] & {7{wb_sel_i[0]}}) : `TBP_RST_REL;

  // ==========================================================
  // Capture input synchronisers
  // Stage one is only read by stage two; edges come from stages two and three
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cap_s1 <= `TBP_RST_PTR;
      cap_s2 <= `TBP_RST_PTR;
      cap_s3 <= `TBP_RST_PTR;
    end
    else
    begin
      cap_s1 <= cap_in;
      cap_s2 <= cap_s1;
      cap_s3 <= cap_s2;
    end
  end

  // ==========================================================
  // Count source
  assign mode = tbp_cnt_mode_t'(ctrl[`TBP_CTRL_MODE_HI:`TBP_CTRL_MODE_LO]);
  assign pwm_mode = ctrl[`TBP_CTRL_PWM];
  assign count_en = ctrl[`TBP_CTRL_EN] && !ctrl[`TBP_CTRL_RST];

  always_comb
  begin
    logic now_v;
    logic was_v;
    now_v = cap_s2[ctrl[`TBP_CTRL_CAPSEL]];
    was_v = cap_s3[ctrl[`TBP_CTRL_CAPSEL]];
    unique case (mode)
      TBP_TIMER: cnt_edge = 1'b1;
      TBP_CAP_RISE: cnt_edge = now_v && !was_v;
      TBP_CAP_FALL: cnt_edge = !now_v && was_v;
      TBP_CAP_BOTH: cnt_edge = now_v != was_v;
    endcase
  end

  assign advance = count_en && cnt_edge;
  assign tick = advance && (pre_count == prescale);

  // ==========================================================
  // Match comparison, one comparator per match register
  genvar gi;
  generate
    for (gi = 0; gi < `TBP_NUM_MATCH; gi++)
    begin : g_match
      assign match_ev[gi] = tick && (count == active[gi]);
      assign int_en[gi] = match_ctrl[`TBP_MC_STRIDE*gi + `TBP_MC_INT];
      assign reset_en[gi] = match_ctrl[`TBP_MC_STRIDE*gi + `TBP_MC_RESET];
      assign stop_en[gi] = match_ctrl[`TBP_MC_STRIDE*gi + `TBP_MC_STOP];
    end
  endgenerate

  // In PWM mode the period match always restarts the cycle
  assign reset_hit = |(match_ev & reset_en) || (pwm_mode && match_ev[0]);
  assign stop_hit = |(match_ev & stop_en);
  assign period_ev = pwm_mode && match_ev[0];

  // ==========================================================
  // Prescaler and main counter
  always_ff @(posedge clk_sys)
  begin
    if (rst || ctrl[`TBP_CTRL_RST])
    begin
      count <= `TBP_RST_WORD;
      pre_count <= `TBP_RST_WORD;
    end
    else if (wr_req && tbp_is(word_sel, `TBP_OFF_COUNT))
    begin
      count <= tbp_merge(count, wr_data, wb_sel_i);
      pre_count <= `TBP_RST_WORD;
    end
    else if (advance)
    begin
      if (pre_count == prescale)
      begin
        pre_count <= `TBP_RST_WORD;
        count <= reset_hit ? `TBP_RST_WORD : count + 32'h0000_0001;
      end
      else
      begin
        pre_count <= pre_count + 32'h0000_0001;
      end
    end
  end

  // ==========================================================
  // Control and configuration registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ctrl <= `TBP_RST_WORD;
    end
    else
    begin
      if (wr_req && tbp_is(word_sel, `TBP_OFF_CTRL))
      begin
        ctrl <= tbp_merge(ctrl, wr_data, wb_sel_i);
      end
      // Stop match beats a simultaneous software write so the halt is never lost
      if (stop_hit)
      begin
        ctrl[`TBP_CTRL_EN] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      prescale <= `TBP_RST_WORD;
      match_ctrl <= `TBP_RST_WORD;
      pwm_ctrl <= `TBP_RST_WORD;
      int_mask <= `TBP_RST_WORD;
    end
    else if (wr_req)
    begin
      if (tbp_is(word_sel, `TBP_OFF_PRESCALE))
      begin
        prescale <= tbp_merge(prescale, wr_data, wb_sel_i);
      end
      if (tbp_is(word_sel, `TBP_OFF_MATCH_CTRL))
      begin
        match_ctrl <= tbp_merge(match_ctrl, wr_data, wb_sel_i) & 32'h001f_ffff;
      end
      if (tbp_is(word_sel, `TBP_OFF_PWM_CTRL))
      begin
        pwm_ctrl <= tbp_merge(pwm_ctrl, wr_data, wb_sel_i) & 32'h0000_7e7c;
      end
      if (tbp_is(word_sel, `TBP_OFF_INT_MASK))
      begin
        int_mask <= tbp_merge(int_mask, wr_data, wb_sel_i) & 32'h0000_007f;
      end
    end
  end

  // ==========================================================
  // Match shadow, release and active values
  // Writes land in the shadow copy; the compare logic only ever sees the active copy
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (int i = 0; i < `TBP_NUM_MATCH; i++)
      begin
        shadow[i] <= `TBP_RST_WORD;
      end
    end
    else if (wr_req && match_hit)
    begin
      shadow[match_idx] <= tbp_merge(shadow[match_idx], wr_data, wb_sel_i);
    end
  end

  assign applied = period_ev ? release_bits : `TBP_RST_REL;

  // A release written in the cycle it is consumed stays pending for the next cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      release_bits <= `TBP_RST_REL;
    end
    else
    begin
      release_bits <= (release_bits & ~applied) | rel_wr;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (int i = 0; i < `TBP_NUM_MATCH; i++)
      begin
        active[i] <= `TBP_RST_WORD;
      end
    end
    else
    begin
      for (int i = 0; i < `TBP_NUM_MATCH; i++)
      begin
        if (!pwm_mode)
        begin
          active[i] <= shadow[i];
        end
        else if (applied[i])
        begin
          active[i] <= shadow[i];
        end
      end
    end
  end

  // ==========================================================
  // PWM outputs
  generate
    for (gi = 1; gi <= `TBP_NUM_OUT; gi++)
    begin : g_out
      logic dbl;
      logic run;
      if (gi == 1)
      begin : g_single
        assign dbl = 1'b0;
      end
      else
      begin : g_select
        assign dbl = pwm_ctrl[gi];
      end
      assign run = pwm_mode && pwm_ctrl[`TBP_PC_ENA_BASE + gi];
      tbp_pwm_ch u_ch (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(run),
        .set_ev(dbl ? match_ev[gi-1] : match_ev[0]),
        .clr_ev(match_ev[gi]),
        .hold_low(!dbl && (active[gi] == `TBP_RST_WORD)),
        .pwm_o(pwm_out[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Interrupts
  // Set beats a same-cycle write-one-to-clear
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      int_status <= `TBP_RST_WORD;
      irq <= 1'b0;
    end
    else
    begin
      int_status[`TBP_NUM_MATCH-1:0] <= (int_status[`TBP_NUM_MATCH-1:0] & ~w1c) |
                                         (match_ev & int_en);
      irq <= |(int_status & int_mask);
    end
  end

  // ==========================================================
  // Read mux and acknowledge
  always_comb
  begin
    next_rd = `TBP_RST_WORD;
    if (match_hit)
    begin
      next_rd = shadow[match_idx];
    end
    else
    begin
      unique case (1'b1)
        tbp_is(word_sel, `TBP_OFF_CTRL): next_rd = ctrl;
        tbp_is(word_sel, `TBP_OFF_COUNT): next_rd = count;
        tbp_is(word_sel, `TBP_OFF_PRESCALE): next_rd = prescale;
        tbp_is(word_sel, `TBP_OFF_PRE_COUNT): next_rd = pre_count;
        tbp_is(word_sel, `TBP_OFF_MATCH_CTRL): next_rd = match_ctrl;
        tbp_is(word_sel, `TBP_OFF_RELEASE): next_rd = {25'h0, release_bits};
        tbp_is(word_sel, `TBP_OFF_PWM_CTRL): next_rd = pwm_ctrl;
        tbp_is(word_sel, `TBP_OFF_INT_STATUS): next_rd = int_status;
        tbp_is(word_sel, `TBP_OFF_INT_MASK): next_rd = int_mask;
        default: next_rd = `TBP_RST_WORD;
      endcase
    end
  end

  // Every access, mapped or not, is answered one cycle later
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `TBP_RST_WORD;
    end
    else
    begin
      wb_ack_o <= access;
      wb_dat_o <= (access && !wb_we_i) ? next_rd : `TBP_RST_WORD;
    end
  end

endmodule
`default_nettype wire

// ==== tbp_chk.sv ====
// Checker for bus handshake, interrupt and pin quiet behaviour
`default_nettype none
`include "tbp_defs.svh"
module tbp_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`TBP_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [1:0] cap_in,
  input wire logic [6:1] pwm_out,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // ==========================================================
  // Sequences
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_wr0(a);
    s_req ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == a);
  endsequence
  // ==========================================================
  // Properties
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_ack_answer;
    s_req |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not acked");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_unmapped;
    s_req ##0 (!wb_we_i && wb_adr_i == 8'h24) |=> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_reset_quiet;
    $fell(rst) |-> pwm_out == 6'h0 && !irq;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs live after reset");
  property p_mask_off;
    s_wr0(`TBP_OFF_INT_MASK) ##0 wb_dat_i[6:0] == 7'h0 |-> ##[1:3] !irq;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("masked irq stays high");
  property p_pwm_off;
    s_wr0(`TBP_OFF_CTRL) ##0 !wb_dat_i[3] |-> ##[1:3] pwm_out == 6'h0;
  endproperty
  a_pwm_off: assert property (p_pwm_off) else $error("pins live in timer mode");
endmodule
bind tbp_top tbp_chk u_tbp_chk (
  .clk_sys(clk_sys),
  .rst(rst),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .cap_in(cap_in),
  .pwm_out(pwm_out),
  .irq(irq)
);
`default_nettype wire

// ==== tbp_load.sv ====
// Load model on the PWM pins counting high cycles and rising edges
`default_nettype none
module tbp_load (
  input wire logic clk_sys,
  input wire logic clr,
  input wire logic [6:1] pin,
  output logic [6:1][7:0] hi,
  output logic [6:1][7:0] rise
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:1] prev = 6'h0;
  // Window counts avoid timing each edge against bus latency
  always_ff @(posedge clk_sys)
  begin
    prev <= pin;
    for (int i = 1; i <= 6; i++)
    begin
      hi[i] <= clr ? 8'h0 : hi[i] + 8'(pin[i]);
      rise[i] <= clr ? 8'h0 : rise[i] + 8'(pin[i] & ~prev[i]);
    end
  end
endmodule
`default_nettype wire

// ==== test_tbp_top.sv ====
// Self-checking bench of the timer-based PWM generator
`default_nettype none
`include "tbp_defs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module test_tbp_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rd_o;
  logic [31:0] rdat;
  logic [1:0] cap = 2'h0;
  logic clr = 1'b0;
  logic [6:1] pwm;
  logic irq;
  logic ack;
  logic [6:1][7:0] hi;
  logic [6:1][7:0] rise;
  logic [31:0] mv [5] = '{32'h9, 32'h3, 32'h7, 32'h2, 32'h0};
  logic [1:0] pat [4] = '{2'b11, 2'b10, 2'b01, 2'b00};
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  always #10 clk_sys = ~clk_sys;
  tbp_top u_tbp_top (
    .clk_sys(clk_sys),
    .rst(rst),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(sel),
    .wb_dat_i(dat),
    .wb_dat_o(rd_o),
    .wb_ack_o(ack),
    .cap_in(cap),
    .pwm_out(pwm),
    .irq(irq)
  );
  tbp_load u_tbp_load (
    .clk_sys(clk_sys),
    .clr(clr),
    .pin(pwm),
    .hi(hi),
    .rise(rise)
  );
  // ==========================================================
  // Tasks
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do @(posedge clk_sys); while (ack !== 1'b1);
    rdat = rd_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Fifty cycles is five whole periods, so counts do not depend on phase
  task automatic meas();
    @(posedge clk_sys);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    repeat (50) @(posedge clk_sys);
    #1;
  endtask
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      wrap_up();
    end
  end
  // ==========================================================
  // Tests
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 0; a < 'h5c; a += 4)
    begin
      bus(1'b0, 8'(a), 32'h0);
      `CHK(rdat, 32'h0)
    end
    bus(1'b1, 8'h24, 32'hffff_ffff);
    bus(1'b0, 8'h24, 32'h0);
    `CHK(rdat, 32'h0)
    $display("test reset values done");
    bus(1'b1, `TBP_OFF_PRESCALE, 32'h3);
    bus(1'b1, `TBP_OFF_MATCH_BASE, 32'h5);
    bus(1'b1, `TBP_OFF_MATCH_CTRL, 32'h5);
    bus(1'b1, `TBP_OFF_INT_MASK, 32'h1);
    bus(1'b1, `TBP_OFF_CTRL, 32'h1);
    n = 0;
    while (irq !== 1'b1 && n < 100)
    begin
      @(posedge clk_sys);
      n++;
    end
    `CHK(n inside {[24:26]}, 1'b1)
    bus(1'b0, `TBP_OFF_CTRL, 32'h0);
    `CHK(rdat[0], 1'b0)
    bus(1'b0, `TBP_OFF_INT_STATUS, 32'h0);
    `CHK(rdat, 32'h1)
    bus(1'b1, `TBP_OFF_INT_MASK, 32'h0);
    repeat (3) @(posedge clk_sys);
    `CHK(irq, 1'b0)
    bus(1'b1, `TBP_OFF_INT_MASK, 32'h1);
    repeat (3) @(posedge clk_sys);
    `CHK(irq, 1'b1)
    bus(1'b1, `TBP_OFF_INT_STATUS, 32'h1);
    repeat (3) @(posedge clk_sys);
    `CHK(irq, 1'b0)
    $display("test timer and interrupt done");
    bus(1'b1, `TBP_OFF_CTRL, 32'h2);
    bus(1'b1, `TBP_OFF_MATCH_CTRL, 32'h0);
    bus(1'b1, `TBP_OFF_PRESCALE, 32'h0);
    for (int i = 0; i < 5; i++)
      bus(1'b1, 8'(`TBP_OFF_MATCH_BASE + 4 * i), mv[i]);
    bus(1'b1, `TBP_OFF_PWM_CTRL, 32'h1e0c);
    bus(1'b1, `TBP_OFF_CTRL, 32'h9);
    repeat (30) @(posedge clk_sys);
    meas();
    `CHK(hi, {8'd0, 8'd0, 8'd0, 8'd25, 8'd20, 8'd20})
    `CHK(rise, {8'd0, 8'd0, 8'd0, 8'd5, 8'd5, 8'd5})
    bus(1'b1, `TBP_OFF_MATCH_BASE + 8'h4, 32'h6);
    repeat (20) @(posedge clk_sys);
    meas();
    `CHK(hi[1], 8'd20)
    bus(1'b1, `TBP_OFF_RELEASE, 32'h2);
    repeat (20) @(posedge clk_sys);
    meas();
    `CHK(hi[2:1], {8'd5, 8'd35})
    `CHK(rise[1], 8'd5)
    bus(1'b1, `TBP_OFF_MATCH_BASE + 8'h14, 32'h5);
    bus(1'b1, `TBP_OFF_MATCH_BASE + 8'h18, 32'h8);
    bus(1'b1, `TBP_OFF_RELEASE, 32'h60);
    bus(1'b1, `TBP_OFF_PWM_CTRL, 32'h7e4c);
    repeat (20) @(posedge clk_sys);
    meas();
    `CHK(hi, {8'd15, 8'd30, 8'd0, 8'd25, 8'd5, 8'd35})
    `CHK(rise, {8'd5, 8'd5, 8'd0, 8'd5, 8'd5, 8'd5})
    $display("test pwm outputs done");
    bus(1'b1, `TBP_OFF_CTRL, 32'h2);
    for (int m = 1; m < 4; m++)
    begin
      bus(1'b1, `TBP_OFF_COUNT, 32'h0);
      bus(1'b1, `TBP_OFF_CTRL, 32'h01 | 32'(m << 4) | ((m == 2) ? 32'h0 : 32'h40));
      for (int p = 0; p < 12; p++)
      begin
        @(posedge clk_sys);
        cap <= pat[p % 4];
        repeat (2) @(posedge clk_sys);
      end
      repeat (6) @(posedge clk_sys);
      bus(1'b0, `TBP_OFF_COUNT, 32'h0);
      `CHK(rdat, (m == 1) ? 32'h3 : 32'h6)
    end
    $display("test capture counting done");
    bus(1'b1, `TBP_OFF_CTRL, 32'h2);
    bus(1'b1, `TBP_OFF_MATCH_CTRL, 32'h18);
    bus(1'b1, `TBP_OFF_CTRL, 32'h1);
    repeat (40) @(posedge clk_sys);
    bus(1'b0, `TBP_OFF_COUNT, 32'h0);
    `CHK(rdat <= 32'h6, 1'b1)
    bus(1'b0, `TBP_OFF_INT_STATUS, 32'h0);
    `CHK(rdat, 32'h2)
    $display("test match reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
